// >>> pkg/anpg_consts.svh
`ifndef ANPG_CONSTS_SVH
`define ANPG_CONSTS_SVH

// ============================================================
// Register offsets
`define ANPG_OFS_LOCAL_NP     5'h07
`define ANPG_OFS_PARTNER_NP   5'h08
`define ANPG_OFS_GIG_CFG      5'h09
`define ANPG_OFS_AN_EXP       5'h06

// ============================================================
// Reset values
`define ANPG_RST_LOCAL_NP     16'h2001
`define ANPG_RST_PARTNER_NP   16'h2001
`define ANPG_RST_GIG_CFG      16'h0300

// ============================================================
// Page word fields
`define ANPG_NP_MORE          15
`define ANPG_NP_ACK           14
`define ANPG_NP_KIND          13
`define ANPG_NP_ACK2          12
`define ANPG_NP_FLIP          11
`define ANPG_NP_CODE_HI       10
`define ANPG_NP_WMASK         16'hb7ff

// ============================================================
// Gigabit config fields
`define ANPG_CFG_TEST_HI      15
`define ANPG_CFG_TEST_LO      13
`define ANPG_CFG_MAN_EN       12
`define ANPG_CFG_MAN_VAL      11
`define ANPG_CFG_PORT_MULTI   10
`define ANPG_CFG_FD_OFFER     9
`define ANPG_CFG_HD_OFFER     8
`define ANPG_CFG_TDR_AUTO     7
`define ANPG_CFG_WMASK        16'hff80

// ============================================================
// Expansion status fields
`define ANPG_EXP_PAGE_RCVD    1
`define ANPG_EXP_RST          16'h0064

`endif

// >>> pkg/anpg_pkg.sv
package anpg_pkg;

   typedef enum logic [2:0] {
      ANPG_TEST_NORMAL,
      ANPG_TEST_WAVEFORM,
      ANPG_TEST_JITTER_MASTER,
      ANPG_TEST_JITTER_SLAVE,
      ANPG_TEST_DISTORTION,
      ANPG_TEST_MLT3_IDLE,
      ANPG_TEST_REP_0001,
      ANPG_TEST_PULSE_63Z
   } anpg_test_e;

   typedef struct packed {
      logic more;
      logic ack;
      logic kind;
      logic ack2;
      logic flip;
      logic [10:0] code;
   } anpg_page_s;

   typedef struct packed {
      logic [4:0] addr;
      logic wr;
      logic rd;
      logic [15:0] wdata;
   } anpg_mgmt_req_s;

   typedef struct packed {
      anpg_test_e test_mode;
      logic manual_role_override_en;
      logic manual_role_value;
      logic port_multi;
      logic gig_full_duplex_offer;
      logic gig_half_duplex_offer;
      logic cable_reflect_autolaunch;
   } anpg_cfg_s;

endpackage

// >>> design/anpg_regs.sv
`timescale 1ns/10ps
`include "anpg_consts.svh"

module anpg_regs
(
   input wire logic clk,
   input wire logic rst_n,
   input anpg_pkg::anpg_mgmt_req_s mgmt_req,
   output logic [15:0] mgmt_rdata,
   output logic mgmt_hit,
   input wire logic strap_fd_offer,
   input wire logic strap_hd_offer,
   input wire logic strap_valid,
   input wire logic local_adv_flip,
   input wire logic partner_base_flip,
   input wire logic np_sent,
   input wire logic np_rcvd,
   input anpg_pkg::anpg_page_s np_rcvd_word,
   input wire logic link_up,
   input wire logic an_restart,
   output anpg_pkg::anpg_page_s np_tx_word,
   output anpg_pkg::anpg_cfg_s cfg,
   output logic role_master,
   output logic tdr_launch,
   output logic page_rcvd_flag
);
   import anpg_pkg::*;

   // ============================================================
   // Access decode
   logic wr_local_np;
   logic wr_gig_cfg;

   assign wr_local_np = mgmt_req.wr && mgmt_req.addr == `ANPG_OFS_LOCAL_NP;
   assign wr_gig_cfg = mgmt_req.wr && mgmt_req.addr == `ANPG_OFS_GIG_CFG;

   // ============================================================
   // Local next page
   logic [15:0] local_np_q;
   logic tx_flip_q;
   logic [15:0] wr_np;
   logic [15:0] wr_cfg;

   assign wr_np = mgmt_req.wdata & `ANPG_NP_WMASK;
   assign wr_cfg = mgmt_req.wdata & `ANPG_CFG_WMASK;

   // Write mask drops the ack bit 14 and the flip bit
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         local_np_q <= `ANPG_RST_LOCAL_NP & `ANPG_NP_WMASK;
      end
      else if (wr_local_np)
      begin
         local_np_q <= wr_np;
      end
   end

   // Flip clears on reset and loads the complement of local base page bit 11 on restart
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         tx_flip_q <= 1'b0;
      end
      else if (an_restart)
      begin
         tx_flip_q <= ~local_adv_flip;
      end
      else if (np_sent)
      begin
         tx_flip_q <= ~tx_flip_q;
      end
   end

   // Flip bit spliced in at read time
   logic [15:0] local_np_rd;
   always_comb
   begin
      local_np_rd = local_np_q;
      local_np_rd[`ANPG_NP_FLIP] = tx_flip_q;
   end

   assign np_tx_word = anpg_page_s'(local_np_rd);

   // ============================================================
   // Partner next page
   logic [15:0] partner_np_q;
   logic rx_flip_q;

   // Storage location fixed at this register
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         partner_np_q <= `ANPG_RST_PARTNER_NP;
      end
      else if (np_rcvd)
      begin
         partner_np_q <= np_rcvd_word;
      end
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rx_flip_q <= 1'b0;
      end
      else if (an_restart)
      begin
         rx_flip_q <= ~partner_base_flip;
      end
      else if (np_rcvd)
      begin
         rx_flip_q <= ~rx_flip_q;
      end
   end

   logic [15:0] partner_np_rd;
   always_comb
   begin
      partner_np_rd = partner_np_q;
      partner_np_rd[`ANPG_NP_FLIP] = rx_flip_q;
   end

   // ============================================================
   // Page received flag, set wins over read clear
   logic page_rcvd_q;
   logic rd_exp;

   assign rd_exp = mgmt_req.rd && mgmt_req.addr == `ANPG_OFS_AN_EXP;

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         page_rcvd_q <= 1'b0;
      end
      else if (np_rcvd)
      begin
         page_rcvd_q <= 1'b1;
      end
      else if (rd_exp)
      begin
         page_rcvd_q <= 1'b0;
      end
   end

   assign page_rcvd_flag = page_rcvd_q;

   // ============================================================
   // Strap pins, three stages, level moves once two stages agree
   logic [1:0] strap_pin;
   logic [1:0] strap_lvl;

   assign strap_pin = {strap_fd_offer, strap_hd_offer};

   for (genvar gi = 0; gi < 2; gi++)
   begin : g_strap
      logic s1_q;
      logic s2_q;
      logic s3_q;
      logic lvl_q;

      always_ff @(posedge clk or negedge rst_n)
      begin
         if (!rst_n)
         begin
            // Nominal offer held until the pins settle
            s1_q <= 1'b1;
            s2_q <= 1'b1;
            s3_q <= 1'b1;
            lvl_q <= 1'b1;
         end
         else
         begin
            s1_q <= strap_pin[gi];
            s2_q <= s1_q;
            s3_q <= s2_q;
            if (s2_q == s3_q)
            begin
               lvl_q <= s3_q;
            end
         end
      end

      assign strap_lvl[gi] = lvl_q;
   end

   // ============================================================
   // Gigabit config
   logic [15:0] cfg_q;
   logic strap_done_q;

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cfg_q <= `ANPG_RST_GIG_CFG;
      end
      else if (wr_gig_cfg)
      begin
         cfg_q <= wr_cfg;
      end
      else if (!strap_done_q && strap_valid)
      begin
         cfg_q[`ANPG_CFG_FD_OFFER] <= strap_lvl[1];
         cfg_q[`ANPG_CFG_HD_OFFER] <= strap_lvl[0];
      end
   end

   // Strap caught once after reset release unless a config write comes at or before strap_valid
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         strap_done_q <= 1'b0;
      end
      else if (strap_valid || wr_gig_cfg)
      begin
         strap_done_q <= 1'b1;
      end
   end

   always_comb
   begin
      cfg.test_mode =
         anpg_test_e'(cfg_q[`ANPG_CFG_TEST_HI:`ANPG_CFG_TEST_LO]);
      cfg.manual_role_override_en = cfg_q[`ANPG_CFG_MAN_EN];
      cfg.manual_role_value = cfg_q[`ANPG_CFG_MAN_VAL];
      cfg.port_multi = cfg_q[`ANPG_CFG_PORT_MULTI];
      cfg.gig_full_duplex_offer = cfg_q[`ANPG_CFG_FD_OFFER];
      cfg.gig_half_duplex_offer = cfg_q[`ANPG_CFG_HD_OFFER];
      cfg.cable_reflect_autolaunch = cfg_q[`ANPG_CFG_TDR_AUTO];
   end

   // Manual role; otherwise multi-port prefers master
   logic role_q;
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         role_q <= 1'b0;
      end
      else if (cfg_q[`ANPG_CFG_MAN_EN])
      begin
         role_q <= cfg_q[`ANPG_CFG_MAN_VAL];
      end
      else
      begin
         role_q <= cfg_q[`ANPG_CFG_PORT_MULTI];
      end
   end

   assign role_master = role_q;

   // ============================================================
   // Reflectometry launch on link drop
   logic link_q;
   logic tdr_q;

   // Low after reset, so no false drop is seen
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         link_q <= 1'b0;
      end
      else
      begin
         link_q <= link_up;
      end
   end

   // One-cycle pulse after a drop, only while enabled
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         tdr_q <= 1'b0;
      end
      else
      begin
         tdr_q <= link_q && !link_up && cfg_q[`ANPG_CFG_TDR_AUTO];
      end
   end

   assign tdr_launch = tdr_q;

   // ============================================================
   // Read path
   always_comb
   begin
      mgmt_hit = 1'b1;
      if (mgmt_req.addr == `ANPG_OFS_LOCAL_NP)
      begin
         mgmt_rdata = local_np_rd;
      end
      else if (mgmt_req.addr == `ANPG_OFS_PARTNER_NP)
      begin
         mgmt_rdata = partner_np_rd;
      end
      else if (mgmt_req.addr == `ANPG_OFS_GIG_CFG)
      begin
         mgmt_rdata = cfg_q;
      end
      else if (mgmt_req.addr == `ANPG_OFS_AN_EXP)
      begin
         mgmt_rdata = `ANPG_EXP_RST;
         mgmt_rdata[`ANPG_EXP_PAGE_RCVD] = page_rcvd_q;
      end
      else
      begin
         mgmt_hit = 1'b0;
         mgmt_rdata = 16'h0000;
      end
   end

endmodule

// >>> test/anpg_monitor.sv
`timescale 1ns/10ps
module anpg_monitor
(
   input wire logic clk,
   input wire logic rst_n,
   input anpg_pkg::anpg_mgmt_req_s mgmt_req,
   input wire logic [15:0] mgmt_rdata,
   input wire logic mgmt_hit,
   input wire logic np_sent,
   input wire logic np_rcvd,
   input anpg_pkg::anpg_page_s np_rcvd_word,
   input wire logic an_restart,
   input wire logic local_adv_flip,
   input wire logic link_up,
   input anpg_pkg::anpg_page_s np_tx_word,
   input anpg_pkg::anpg_cfg_s cfg,
   input wire logic role_master,
   input wire logic tdr_launch,
   input wire logic page_rcvd_flag
);
   import anpg_pkg::*;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   // =======
   // Read side, config write, role, reflectometry, page flag and flip checks
   unmapped_zero_a: assert property (!mgmt_hit |-> mgmt_rdata == 16'h0)
      else $error("unmapped read not zero");
   hit_decode_a: assert property (mgmt_hit == (mgmt_req.addr inside
      {[5'h06:5'h09]})) else $error("hit decode wrong");
   cfg_rsv_a: assert property (mgmt_req.addr == 5'h09
      |-> mgmt_rdata[6:0] == 7'h0) else $error("reserved bits set");
   test_write_a: assert property (mgmt_req.wr && mgmt_req.addr == 5'h09
      |=> cfg.test_mode == $past(mgmt_req.wdata[15:13]))
      else $error("test mode not written");
   role_pick_a: assert property (role_master ==
      ($past(cfg.manual_role_override_en) ? $past(cfg.manual_role_value)
      : $past(cfg.port_multi))) else $error("role wrong");
   tdr_fire_a: assert property ($fell(link_up)
      && cfg.cable_reflect_autolaunch |-> ##[0:1] tdr_launch)
      else $error("no reflectometry launch");
   flag_set_a: assert property (np_rcvd |=> page_rcvd_flag)
      else $error("page flag not set");
   page_store_a: assert property (np_rcvd ##1 mgmt_req.addr == 5'h08
      |-> (mgmt_rdata & 16'hf7ff) == ($past(np_rcvd_word) & 16'hf7ff))
      else $error("partner page not stored");
   flip_send_a: assert property (np_sent && !an_restart
      |=> np_tx_word.flip != $past(np_tx_word.flip))
      else $error("flip did not invert");
   flip_load_a: assert property (an_restart
      |=> np_tx_word.flip == !$past(local_adv_flip))
      else $error("flip not reloaded");
endmodule
bind anpg_regs anpg_monitor i_mon (.clk, .rst_n, .mgmt_req, .mgmt_rdata,
   .mgmt_hit, .np_sent, .np_rcvd, .np_rcvd_word, .an_restart,
   .local_adv_flip, .link_up, .np_tx_word, .cfg, .role_master, .tdr_launch,
   .page_rcvd_flag);

// >>> test/anpg_partner.sv
`timescale 1ns/10ps
module anpg_partner
(
   input wire logic clk,
   input wire logic go,
   input anpg_pkg::anpg_page_s word,
   output logic np_rcvd,
   output anpg_pkg::anpg_page_s np_rcvd_word
);
   import anpg_pkg::*;
   initial np_rcvd = 1'b0;
   initial np_rcvd_word = '0;
   // Word scrambles between pages
   always @(posedge clk)
   begin
      np_rcvd <= go;
      np_rcvd_word <= go ? word : ~np_rcvd_word;
   end
endmodule

// >>> test/tb.sv
`timescale 1ns/10ps
module tb;
   import anpg_pkg::*;
   logic clk = 1'b0, rst_n = 1'b0;
   anpg_mgmt_req_s req = '0;
   logic [15:0] rdata, d, e;
   logic hit, sfd = 1'b0, shd = 1'b1, sval = 1'b0;
   logic lflip = 1'b1, sent = 1'b0, link = 1'b0, rst_an = 1'b0;
   logic go = 1'b0, np_rcvd, role, tdr, flag, pflip = 1'b0, rf;
   anpg_page_s word = '0, rword, txw;
   anpg_cfg_s cfg;
   int errors = 0, samples_checked = 0;
   logic [31:0] s = 32'ha;
   logic [4:0] ad [5] = '{5'h07, 5'h08, 5'h09, 5'h06, 5'h0a};
   logic [15:0] rv [5] = '{16'h2001, 16'h2001, 16'h0300, 16'h0064, 16'h0};
   always #10 clk = ~clk;
   anpg_regs i_dut (.clk(clk), .rst_n(rst_n), .mgmt_req(req),
      .mgmt_rdata(rdata), .mgmt_hit(hit), .strap_fd_offer(sfd),
      .strap_hd_offer(shd), .strap_valid(sval), .local_adv_flip(lflip),
      .partner_base_flip(pflip), .np_sent(sent), .np_rcvd(np_rcvd),
      .np_rcvd_word(rword), .link_up(link), .an_restart(rst_an),
      .np_tx_word(txw), .cfg(cfg), .role_master(role), .tdr_launch(tdr),
      .page_rcvd_flag(flag));
   anpg_partner i_lp (.clk(clk), .go(go), .word(word), .np_rcvd(np_rcvd),
      .np_rcvd_word(rword));
   // =======
   // Helpers
   function automatic logic [31:0] xs(input logic [31:0] v);
      logic [31:0] x;
      x = v ^ (v << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         errors++;
         $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [4:0] a, input logic [15:0] v);
      @(negedge clk);
      req = '{a, 1'b1, 1'b0, v};
      @(negedge clk);
      req.wr = 1'b0;
   endtask
   task automatic rd(input logic [4:0] a, input logic [15:0] v, input logic c);
      @(negedge clk);
      req.addr = a;
      req.rd = c;
      #2 chk(rdata, v);
      @(negedge clk);
      req.rd = 1'b0;
   endtask
   task automatic final_report;
      $display("errors %0d samples_checked %0d", errors, samples_checked);
      if (errors == 0 && samples_checked > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   // =======
   // Scenarios
   initial
   begin
      repeat (5) @(negedge clk);
      rst_n = 1'b1;
      for (int i = 0; i < 5; i++)
         rd(ad[i], rv[i], 1'b0);
      chk({15'h0, hit}, 16'h0);
      @(negedge clk);
      sval = 1'b1;
      @(negedge clk);
      sval = 1'b0;
      rd(5'h09, 16'h0100, 1'b0);
      for (int i = 0; i < 8; i++)
      begin
         s = xs(s);
         d = {i[2:0], s[12:0]};
         wr(5'h09, d);
         rd(5'h09, d & 16'hff80, 1'b0);
         chk({13'h0, cfg.test_mode}, {13'h0, i[2:0]});
         chk({15'h0, role}, {15'h0, d[12] ? d[11] : d[10]});
         chk({7'h0, cfg}, {7'h0, d[15:7]});
      end
      s = xs(s);
      e = s[15:0] & 16'hb7ff;
      wr(5'h07, s[15:0]);
      rd(5'h07, e, 1'b0);
      chk(txw, e);
      wr(5'h08, 16'hffff);
      rd(5'h08, 16'h2001, 1'b0);
      @(negedge clk);
      sent = 1'b1;
      @(negedge clk);
      sent = 1'b0;
      rd(5'h07, e | 16'h0800, 1'b0);
      chk(txw, e | 16'h0800);
      @(negedge clk);
      rst_an = 1'b1;
      @(negedge clk);
      rst_an = 1'b0;
      rf = ~pflip;
      rd(5'h07, e, 1'b0);
      for (int i = 0; i < 3; i++)
      begin
         s = xs(s);
         word = s[15:0];
         @(negedge clk);
         go = 1'b1;
         req.addr = 5'h08;
         @(negedge clk);
         go = 1'b0;
         @(negedge clk);
         chk(rdata & 16'hf7ff, word & 16'hf7ff);
         rf = ~rf;
         chk({15'h0, rdata[11]}, {15'h0, rf});
         chk({15'h0, flag}, 16'h1);
      end
      rd(5'h06, 16'h0066, 1'b1);
      rd(5'h06, 16'h0064, 1'b0);
      wr(5'h09, 16'h0080);
      for (int i = 0; i < 2; i++)
      begin
         @(negedge clk);
         link = 1'b1;
         @(negedge clk);
         link = 1'b0;
         @(negedge clk);
         chk({15'h0, tdr}, {15'h0, i == 0});
         @(negedge clk);
         chk({15'h0, tdr}, 16'h0);
         wr(5'h09, 16'h0000);
      end
      final_report;
   end
   initial
   begin
      #100000;
      errors++;
      final_report;
   end
endmodule
